// [sim/pdt_checker.sv]
// Port checker for the timer.
// Assumes one pclk domain.
`timescale 1ns/1ns
`default_nettype none
module pdt_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_pin_oe,
  input wire logic irq_req,
  input wire logic wake_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence ctl_wr_s;
    psel && penable && pready && pwrite && paddr == 12'h350;
  endsequence
  wake_same_a: assert property (wake_req == irq_req)
    else $error("wake differs");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready long");
  ready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  map_err_a: assert property (pready && paddr > 12'h350 |-> pslverr)
    else $error("no slave error");
  div_top_a: assert property (pready && !pwrite && paddr == 12'h348
    |-> !prdata[31:7]) else $error("divider top bits");
  reset_quiet_a: assert property ($rose(presetn)
    |-> !irq_req && !timer_pin_oe) else $error("busy after reset");
  oe_drop_a: assert property (ctl_wr_s ##0 !pwdata[5]
    |=> ##1 !timer_pin_oe) else $error("pin still driven");
  irq_drop_a: assert property (ctl_wr_s ##0 !pwdata[6]
    |=> ##1 !irq_req) else $error("irq held");
endmodule
bind pdt_timer pdt_checker pdt_checker_i (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .timer_pin_oe, .irq_req, .wake_req);
`default_nettype wire

// [sim/pdt_pin_src.sv]
// Far-side pulse source on the timer pin.
// Assumes the bench resolves the shared wire.
`timescale 1ns/1ns
`default_nettype none
module pdt_pin_src (
  output logic pin
);
  initial pin = 1'b0;
  // Off-grid edges keep the pin asynchronous
  task automatic pulses(input int n, input int h);
    repeat (n) begin
      #h pin = 1'b1;
      #h pin = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [sim/pdt_timer_test.sv]
// Self-checking bench of the timer over APB.
// Assumes checker and pin source compiled first.
`timescale 1ns/1ns
`default_nettype none
module pdt_timer_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic timer_pin_out, timer_pin_oe, irq_req, wake_req, src_pin;
  logic [31:0] rng = 32'h696C0535;
  int mismatches = 0, checked = 0, cnt, i, t;
  wire logic pin_w = timer_pin_oe ? timer_pin_out : src_pin;
  pdt_timer pdt_timer_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_pin_in(pin_w),
    .timer_pin_out, .timer_pin_oe, .irq_req, .wake_req);
  pdt_pin_src pdt_pin_src_i (.pin(src_pin));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] s;
    s = v ^ (v << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %0t: %0h not %0h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      mismatches++;
      close_out();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h348, 32'h7F);
    rd(12'h34C, 32'hFF);
    rd(12'h350, 32'h0);
    apb(1'b0, 12'h354, 32'h0);
    chk(err, 32'h1);
    apb(1'b1, 12'h348, 32'h15);
    rd(12'h348, 32'h7F);
    apb(1'b1, 12'h34C, 32'h2);
    apb(1'b1, 12'h350, 32'h78);
    for (i = 0; i < 100 && irq_req !== 1'b1; i++) @(posedge pclk);
    chk(irq_req, 32'h1);
    chk(wake_req, 32'h1);
    chk(timer_pin_out, 32'h1);
    rd(12'h350, 32'hF8);
    // Level change with flag low must not reach the pin
    apb(1'b1, 12'h350, 32'h68);
    repeat (2) @(posedge pclk);
    chk(irq_req, 32'h0);
    chk(timer_pin_out, 32'h1);
    apb(1'b1, 12'h350, 32'h0);
    rng = xs(rng);
    cnt = rng[7:0];
    apb(1'b1, 12'h34C, rng);
    rd(12'h34C, cnt);
    for (t = 0; t < 8; t++) begin
      apb(1'b1, 12'h350, t);
      apb(1'b1, 12'h350, 32'h8 | t);
      pdt_pin_src_i.pulses((2 << t) - 1, t[0] ? 750 : 350);
      repeat (6) @(posedge pclk);
      cnt = (cnt - 1) & 8'hFF;
      rd(12'h34C, cnt);
    end
    apb(1'b1, 12'h350, 32'h18);
    repeat (60) @(posedge pclk);
    rd(12'h34C, cnt);
    // Pin low in gated mode, so the loaded value stays put
    apb(1'b1, 12'h348, 32'h15);
    rd(12'h348, 32'h15);
    close_out();
  end
endmodule
`default_nettype wire

// [verilog/pdt_defines.svh]
// Constants of the prescaled down timer: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the package and the timer module.
`ifndef PDT_DEFINES_SVH
`define PDT_DEFINES_SVH

// Register indices; byte address is four times the index
`define PDT_IDX_DIVIDER 10'h0D2
`define PDT_IDX_COUNT 10'h0D3
`define PDT_IDX_CTRL 10'h0D4
`define PDT_ADDR_W 12

// Control field positions
`define PDT_BIT_FLAG 7
`define PDT_BIT_IRQ_EN 6
`define PDT_BIT_DRIVE 5
`define PDT_BIT_LEVEL 4
`define PDT_BIT_RUN 3

// Reset values
`define PDT_RST_COUNT 8'hFF
`define PDT_RST_DIVIDER 7'h7F
`define PDT_RST_CTRL 8'h00
`define PDT_COUNT_ZERO 8'h00

// Core clock divide for the internal prescaler input
`define PDT_CORE_DIV 12
`define PDT_CORE_DIV_LAST 4'hB

`endif

// [verilog/pdt_pkg.sv]
// Types of the prescaled down timer.
// Assumes pdt_defines.svh is on the include path.
`include "pdt_defines.svh"

package pdt_pkg;

  typedef struct packed {
    logic flag;
    logic irq_en;
    logic drive_sel;
    logic level;
    logic run;
    logic [2:0] tap;
  } pdt_ctrl_t;

  typedef struct packed {
    pdt_ctrl_t ctrl;
    logic [7:0] count;
    logic [6:0] divider;
    logic [3:0] core_div;
    logic [2:0] pin_sync;
    logic pin_level;
    logic pin_out;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic wake;
  } pdt_state_t;

  typedef struct packed {
    logic out;
    logic oe;
  } pdt_pin_drive_t;

endpackage

// [verilog/pdt_timer.sv]
// Prescaled down timer: 8-bit down counter behind a 7-bit prescaler,
// with event, gated and output modes on one timer pin, APB registers.
// Assumes a single pclk domain; the timer pin is asynchronous to it.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "pdt_defines.svh"

module pdt_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PDT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_pin_in,
  output logic timer_pin_out,
  output logic timer_pin_oe,
  output logic irq_req,
  output logic wake_req
);

  pdt_pkg::pdt_state_t st_r;
  pdt_pkg::pdt_state_t st_nxt;

  // Register decode, used for both read and write paths
  function automatic logic [1:0] pdt_decode(
    input logic [`PDT_ADDR_W-1:0] addr
  );
    logic [1:0] sel;
    sel = 2'h0;
    if (addr[1:0] == 2'h0) begin
      if (addr[`PDT_ADDR_W-1:2] == `PDT_IDX_DIVIDER) begin
        sel = 2'h1;
      end else if (addr[`PDT_ADDR_W-1:2] == `PDT_IDX_COUNT) begin
        sel = 2'h2;
      end else if (addr[`PDT_ADDR_W-1:2] == `PDT_IDX_CTRL) begin
        sel = 2'h3;
      end
    end
    return sel;
  endfunction

  // Tap event: factor 1 is the input event, else rising prescaler bit
  function automatic logic pdt_tap_event(
    input logic [2:0] tap,
    input logic in_event,
    input logic [6:0] old_div,
    input logic [6:0] new_div
  );
    logic ev;
    ev = 1'b0;
    if (tap == 3'h0) begin
      ev = in_event;
    end else begin
      ev = in_event & ~old_div[tap - 3'h1] & new_div[tap - 3'h1];
    end
    return ev;
  endfunction

  logic [1:0] reg_sel;
  logic access;
  logic wr_commit;
  logic core_tick;
  logic pin_stable;
  logic pin_now;
  logic pin_rise;
  logic in_event;
  logic tap_event;
  logic [6:0] div_dec;
  logic hw_zero;
  logic sw_flag_set;
  logic count_wr;
  logic ctrl_wr;
  logic div_wr;

  assign reg_sel = pdt_decode(paddr);
  assign access = psel & penable;
  // Commit on the edge where pready is seen high
  assign wr_commit = access & st_r.pready & pwrite;
  assign count_wr = wr_commit & (reg_sel == 2'h2);
  assign ctrl_wr = wr_commit & (reg_sel == 2'h3);
  assign div_wr = wr_commit & (reg_sel == 2'h1);
  assign core_tick = (st_r.core_div == `PDT_CORE_DIV_LAST);
  // Third-stage agreement filters a late settling second stage
  assign pin_stable = (st_r.pin_sync[1] == st_r.pin_sync[2]);
  assign pin_now = pin_stable ? st_r.pin_sync[2] : st_r.pin_level;
  assign pin_rise = pin_now & ~st_r.pin_level;
  assign div_dec = st_r.divider - 7'h01;

  always_comb begin
    st_nxt = st_r;
    in_event = 1'b0;
    tap_event = 1'b0;
    hw_zero = 1'b0;
    sw_flag_set = 1'b0;

    // Core clock divided by 12
    if (core_tick) begin
      st_nxt.core_div = 4'h0;
    end else begin
      st_nxt.core_div = st_r.core_div + 4'h1;
    end

    // Pin synchroniser, stage one feeds only stage two
    st_nxt.pin_sync = {st_r.pin_sync[1:0], timer_pin_in};
    st_nxt.pin_level = pin_now;

    // Prescaler input per mode
    if (st_r.ctrl.drive_sel) begin
      in_event = core_tick;
    end else if (st_r.ctrl.level) begin
      in_event = core_tick & pin_now;
    end else begin
      in_event = pin_rise;
    end

    // Prescaler and counter
    if (!st_r.ctrl.run) begin
      st_nxt.divider = `PDT_RST_DIVIDER;
    end else if (div_wr) begin
      st_nxt.divider = pwdata[6:0];
    end else if (in_event) begin
      st_nxt.divider = div_dec;
      tap_event = pdt_tap_event(st_r.ctrl.tap, in_event,
                                st_r.divider, div_dec);
    end

    if (count_wr) begin
      // Software load wins over a coincident decrement
      st_nxt.count = pwdata[7:0];
      sw_flag_set = (pwdata[7:0] == `PDT_COUNT_ZERO);
    end else if (tap_event && st_r.ctrl.run) begin
      st_nxt.count = st_r.count - 8'h01;
      hw_zero = (st_nxt.count == `PDT_COUNT_ZERO);
    end

    // Control register; hardware set beats software clear
    if (ctrl_wr) begin
      st_nxt.ctrl = pwdata[7:0];
    end
    if (hw_zero || sw_flag_set) begin
      st_nxt.ctrl.flag = 1'b1;
    end

    // Output latch transparent while the flag is high
    if (st_nxt.ctrl.flag) begin
      st_nxt.pin_out = st_nxt.ctrl.level;
    end

    // Request level follows flag and enable
    st_nxt.irq = st_nxt.ctrl.flag & st_nxt.ctrl.irq_en;
    st_nxt.wake = st_nxt.ctrl.flag & st_nxt.ctrl.irq_en;

    // APB: one wait state, then answer
    st_nxt.pready = access & ~st_r.pready;
    st_nxt.pslverr = 1'b0;
    if (access && !st_r.pready) begin
      st_nxt.pslverr = (reg_sel == 2'h0);
      st_nxt.prdata = 32'h0000_0000;
      if (!pwrite) begin
        unique case (reg_sel)
          2'h1: st_nxt.prdata = {25'h0, st_r.divider};
          2'h2: st_nxt.prdata = {24'h0, st_r.count};
          2'h3: st_nxt.prdata = {24'h0, st_r.ctrl};
          default: st_nxt.prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.ctrl <= `PDT_RST_CTRL;
      st_r.count <= `PDT_RST_COUNT;
      st_r.divider <= `PDT_RST_DIVIDER;
      st_r.core_div <= 4'h0;
      st_r.pin_sync <= 3'h0;
      st_r.pin_level <= 1'b0;
      st_r.pin_out <= 1'b0;
      st_r.pready <= 1'b0;
      st_r.pslverr <= 1'b0;
      st_r.prdata <= 32'h0000_0000;
      st_r.irq <= 1'b0;
      st_r.wake <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from flops; oe is the drive bit itself
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign timer_pin_out = st_r.pin_out;
  assign timer_pin_oe = st_r.ctrl.drive_sel;
  assign irq_req = st_r.irq;
  assign wake_req = st_r.wake;

endmodule

`default_nettype wire
